// >>> dv/ir_led_load.sv
// ****
// Infrared LED load: measures high and low run lengths on the pin
// ****
module ir_led_load (
	input  wire logic clock,    // Clock
	input  wire logic pin,      // Carrier pin
	output int        high_len, // Last high run
	output int        low_len   // Last low run
);
	timeunit 1ns;
	timeprecision 1ns;
	int   run = 0;
	logic prev = 1'b0;
	always @(posedge clock) begin
		prev <= pin;
		if (pin !== prev) begin
			if (prev) high_len <= run;
			else low_len <= run;
			run <= 1;
		end else run <= run + 1;
	end
endmodule // ir_led_load

// >>> dv/ir_timer_carrier_gen_tb.sv
`include "ir_timer_map.vh"

module ir_timer_carrier_gen_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] LIM = 8'h03, HI = 8'h01, LO = 8'h02;
	logic       clock, reset_n, periph_put, periph_get, rf_write, flag_clear;
	logic [7:0] periph_addr, data_transfer_buffer, periph_rdata_ff, rf_addr, rd;
	logic [3:0] rf_wdata, rf_rdata_ff, nib;
	logic       timer_match_flag, remote_output_pin;
	int         num_errors, num_checks, cycles, high_len, low_len, n;
	int per[4] = '{(LIM+1)*32, (LIM+1)*64, (LIM+1)*256, (LIM+1)*(HI+LO+2)*2};
	ir_timer_carrier_gen ir_timer_carrier_gen_i (.clock(clock), .reset_n(reset_n),
		.periph_addr(periph_addr), .periph_put(periph_put), .periph_get(periph_get),
		.data_transfer_buffer(data_transfer_buffer), .periph_rdata_ff(periph_rdata_ff),
		.rf_addr(rf_addr), .rf_write(rf_write), .rf_wdata(rf_wdata), .rf_rdata_ff(rf_rdata_ff),
		.flag_clear(flag_clear), .timer_match_flag(timer_match_flag),
		.remote_output_pin(remote_output_pin));
	ir_led_load ir_led_load_i (.clock(clock), .pin(remote_output_pin), .high_len(high_len),
		.low_len(low_len));
	task results;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task chkn(input int got, input int exp);
		num_checks++;
		if (got != exp) begin
			num_errors++;
			$display("wrong value at %0t: got %0d want %0d", $time, got, exp);
		end
	endtask
	task chk8(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task put(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		periph_addr = a;
		data_transfer_buffer = d;
		periph_put = 1'b1;
		@(negedge clock);
		periph_put = 1'b0;
	endtask
	task get(input logic [7:0] a);
		@(negedge clock);
		periph_addr = a;
		periph_get = 1'b1;
		@(negedge clock);
		periph_get = 1'b0;
		rd = periph_rdata_ff;
	endtask
	task rfw(input logic [7:0] a, input logic [3:0] d);
		@(negedge clock);
		rf_addr = a;
		rf_wdata = d;
		rf_write = 1'b1;
		@(negedge clock);
		rf_write = 1'b0;
	endtask
	task rfr(input logic [7:0] a);
		@(negedge clock);
		rf_addr = a;
		@(negedge clock);
		nib = rf_rdata_ff;
	endtask
	// Cycles between two matches, timed from a flag clear
	task period(input int exp);
		n = 0;
		while (timer_match_flag !== 1'b1 && n < 3000) begin
			@(negedge clock);
			n++;
		end
		flag_clear = 1'b1;
		@(negedge clock);
		flag_clear = 1'b0;
		n = 1;
		while (timer_match_flag !== 1'b1 && n < 3000) begin
			@(negedge clock);
			n++;
		end
		chkn(n, exp);
	endtask
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			results;
		end
	end
	initial begin
		{periph_put, periph_get, rf_write, flag_clear, reset_n} = '0;
		{periph_addr, data_transfer_buffer, rf_addr, rf_wdata} = '0;
		repeat (5) @(negedge clock);
		reset_n = 1'b1;
		get(`PR_TIMER_COUNT_VALUE);
		chk8(rd, `RST_TIMER_COUNT);
		rfr(`RF_TIMER_CONTROL);
		chk8({4'h0, nib}, {4'h0, `RST_TIMER_CONTROL});
		get(`PR_TIMER_MATCH_LIMIT);
		chk8(rd, 8'h00);
		get(8'h09);
		chk8(rd, 8'h00);
		rfr(`RF_CARRIER_CONTROL);
		chk8({4'h0, nib}, 8'h00);
		$display("test reset done");
		rfw(`RF_TIMER_CONTROL, 4'h4);
		put(`PR_TIMER_COUNT_VALUE, 8'h55);
		repeat (100) @(negedge clock);
		get(`PR_TIMER_COUNT_VALUE);
		chk8(rd, 8'h00);
		rfr(`RF_TIMER_CONTROL);
		chk8({4'h0, nib}, 8'h00);
		put(`PR_CARRIER_HIGH_PERIOD, HI);
		get(`PR_CARRIER_HIGH_PERIOD);
		chk8(rd, HI);
		put(`PR_CARRIER_LOW_PERIOD, LO);
		get(`PR_CARRIER_LOW_PERIOD);
		chk8(rd, LO);
		$display("test access done");
		put(`PR_TIMER_MATCH_LIMIT, LIM);
		for (int s = 0; s < 4; s++) begin
			rfw(`RF_TIMER_CONTROL, {2'b11, s[1:0]});
			period(per[s]);
		end
		rfw(`RF_TIMER_CONTROL, 4'hc);
		chk8({7'h0, timer_match_flag}, 8'h00);
		$display("test timer done");
		put(`PR_TIMER_MATCH_LIMIT, 8'h00);
		repeat (8400) @(negedge clock);
		chk8({7'h0, timer_match_flag}, 8'h00);
		$display("test zero limit done");
		rfw(`RF_TIMER_CONTROL, 4'h4);
		rfw(`RF_CARRIER_CONTROL, 4'h1);
		repeat (60) @(negedge clock);
		chkn(high_len, (HI + 1) * 2);
		chkn(low_len, (LO + 1) * 2);
		put(`PR_CARRIER_LOW_PERIOD, 8'h80 | LO);
		repeat (30) @(negedge clock);
		chk8({7'h0, remote_output_pin}, 8'h01);
		put(`PR_CARRIER_LOW_PERIOD, LO);
		rfw(`RF_CARRIER_CONTROL, 4'h0);
		repeat (3) @(negedge clock);
		chk8({7'h0, remote_output_pin}, 8'h00);
		$display("test carrier done");
		put(`PR_TIMER_MATCH_LIMIT, LIM);
		rfw(`RF_CARRIER_CONTROL, 4'h2);
		rfw(`RF_TIMER_CONTROL, 4'hc);
		period(per[0]);
		rfr(`RF_CARRIER_CONTROL);
		chk8({7'h0, nib[0]}, 8'h01);
		$display("test buffer copy done");
		put(`PR_CARRIER_HIGH_PERIOD, 8'h7f);
		rfw(`RF_TIMER_CONTROL, 4'hc);
		period(per[0]);
		rfw(`RF_CARRIER_CONTROL, 4'h0);
		rfw(`RF_CARRIER_CONTROL, 4'h1);
		repeat (300) @(negedge clock);
		chkn(high_len, (8'h7f + 1) * 2);
		chk8({7'h0, remote_output_pin}, 8'h00);
		$display("test deferred update done");
		results;
	end
endmodule // ir_timer_carrier_gen_tb

bind ir_timer_carrier_gen ir_timer_checker ir_timer_checker_i (.clock(clock), .reset_n(reset_n),
	.periph_addr(periph_addr), .periph_put(periph_put), .periph_get(periph_get),
	.data_transfer_buffer(data_transfer_buffer), .periph_rdata_ff(periph_rdata_ff),
	.rf_addr(rf_addr), .rf_write(rf_write), .rf_wdata(rf_wdata), .rf_rdata_ff(rf_rdata_ff),
	.flag_clear(flag_clear), .timer_match_flag(timer_match_flag),
	.remote_output_pin(remote_output_pin));

// >>> dv/ir_timer_checker.sv
`include "ir_timer_map.vh"

module ir_timer_checker (
	input wire logic       clock,                // Clock
	input wire logic       reset_n,              // Reset
	input wire logic [7:0] periph_addr,          // Reg address
	input wire logic       periph_put,           // Reg write
	input wire logic       periph_get,           // Reg read
	input wire logic [7:0] data_transfer_buffer, // Write data
	input wire logic [7:0] periph_rdata_ff,      // Read data
	input wire logic [7:0] rf_addr,              // File address
	input wire logic       rf_write,             // File write
	input wire logic [3:0] rf_wdata,             // File data
	input wire logic [3:0] rf_rdata_ff,          // File read
	input wire logic       flag_clear,           // Flag clear
	input wire logic       timer_match_flag,     // Match flag
	input wire logic       remote_output_pin     // Carrier pin
);
	timeunit 1ns;
	timeprecision 1ns;
	wire car = periph_addr == `PR_CARRIER_HIGH_PERIOD || periph_addr == `PR_CARRIER_LOW_PERIOD;
	wire ctl = rf_addr == `RF_TIMER_CONTROL;
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	sequence s_period_rw;
		periph_put && car ##2 periph_get && car;
	endsequence
	sequence s_ctrl_rw;
		rf_write && ctl ##1 !rf_write && ctl ##1 !rf_write && ctl;
	endsequence
	chk_limit_reads_zero: assert property (periph_get && periph_addr == `PR_TIMER_MATCH_LIMIT
		|=> periph_rdata_ff == 8'h00) else $error("limit read not zero");
	chk_clear_reads_zero: assert property (ctl |=> !rf_rdata_ff[`TC_CLEAR_BIT])
		else $error("clear bit read not zero");
	chk_pin_low_off: assert property ($past(rf_addr) == `RF_CARRIER_CONTROL
		&& !rf_rdata_ff[`CC_ENABLE_BIT] |-> !remote_output_pin) else $error("pin high while off");
	chk_pin_drop_write: assert property (rf_write && rf_addr == `RF_CARRIER_CONTROL
		&& !rf_wdata[`CC_ENABLE_BIT] |-> ##2 !remote_output_pin) else $error("pin not dropped");
	chk_data_stands: assert property (!$past(periph_get) |-> $stable(periph_rdata_ff))
		else $error("read data moved");
	chk_flag_stands: assert property (timer_match_flag && !flag_clear && !(rf_write
		&& (ctl || rf_addr == `RF_TIMER_FLAG)) |=> timer_match_flag) else $error("flag lost");
	chk_ctrl_readback: assert property (s_ctrl_rw |=> rf_rdata_ff[3] == $past(rf_wdata[3], 3)
		&& rf_rdata_ff[1:0] == $past(rf_wdata[1:0], 3)) else $error("control readback");
	chk_period_readback: assert property (s_period_rw
		|=> periph_rdata_ff[6:0] == $past(data_transfer_buffer[6:0], 3)) else $error("period readback");
endmodule // ir_timer_checker

// >>> rtl/carrier_gen.v
`include "ir_timer_map.vh"

// ****************************************************************
// Carrier generator: 7-bit counter, high and low phase modulo
// ****************************************************************
module carrier_gen #(
	parameter CNT_W = 7
) (
	input  wire             clock,       // System clock
	input  wire             reset_n,     // Synchronous reset, active low
	input  wire             run,         // Generator may run
	input  wire             gen_tick,    // Carrier generation clock enable
	input  wire [CNT_W-1:0] high_period, // High phase value
	input  wire [CNT_W-1:0] low_period,  // Low phase value
	output reg              carrier_ff,  // Carrier level
	output wire             fall         // Pulse when carrier goes low
);
	reg  [CNT_W-1:0] cnt_ff;
	wire [CNT_W-1:0] limit = carrier_ff ? high_period : low_period;
	wire             last  = (cnt_ff == limit);

	// Phase lasts value plus one generation clock
	always @(posedge clock) begin
		if (!reset_n || !run) begin
			cnt_ff     <= {CNT_W{1'b0}};
			carrier_ff <= 1'b0;
		end else if (gen_tick) begin
			if (last) begin
				cnt_ff     <= {CNT_W{1'b0}};
				carrier_ff <= ~carrier_ff;
			end else begin
				cnt_ff <= cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

	assign fall = run && gen_tick && last && carrier_ff;
endmodule // carrier_gen

// >>> rtl/ir_timer_carrier_gen.v
// Operation
// - Count equals limit sets match flag
// - Count readable only, limit write only
// - Select fx/32, fx/64, fx/256 or carrier
// - Clear strobe resets count and flag
// - Enable bit halts or runs counting
// - Control nibble: enable, clear, select bits
// - Zero limit never raises match flag
// - Seven-bit counter with high/low values
// - Generation clock fx/2 or fx, build option
// - Both carrier period registers read back
// - Low register bit 7 forces steady high
// - Enable one gives carrier, zero low
// - Timer event copies buffer into enable
// - Update waits while carrier output high
// - Generator stops unless output enabled or timer uses it
// - Each phase lasts value plus one
// - First pulse shortened or delayed
`include "ir_timer_map.vh"

module ir_timer_carrier_gen #(
	parameter GEN_UNDIVIDED = 0 // 0: fx/2, 1: fx
) (
	input  wire       clock,           // System oscillator clock
	input  wire       reset_n,         // Synchronous reset, active low
	input  wire [7:0] periph_addr,     // Peripheral register address
	input  wire       periph_put,      // Write data buffer to register
	input  wire       periph_get,      // Read register into data buffer
	input  wire [7:0] data_transfer_buffer, // Data buffer write value
	output reg  [7:0] periph_rdata_ff, // Data buffer read value
	input  wire [7:0] rf_addr,         // Register file address
	input  wire       rf_write,        // Register file write strobe
	input  wire [3:0] rf_wdata,        // Register file write nibble
	output reg  [3:0] rf_rdata_ff,     // Register file read nibble
	input  wire       flag_clear,      // Software clears match flag
	output wire       timer_match_flag, // Timer match flag level
	output reg        remote_output_pin // Remote carrier output
);
	// ****************************************************************
	// Registers
	// ****************************************************************
	reg  [7:0] timer_count_value_ff;
	reg  [7:0] timer_match_limit_ff;
	reg        timer_count_enable_ff;
	reg        timer_clk_sel_hi_ff;
	reg        timer_clk_sel_lo_ff;
	reg        match_flag_ff;
	reg        wrap_ff;
	reg  [7:0] carrier_high_period_ff;
	reg  [7:0] carrier_low_period_ff;
	reg        carrier_enable_ff;
	reg        carrier_enable_buffer_ff;
	reg        pending_ff;
	reg        pending_val_ff;

	wire       tick_2;
	wire       tick_32;
	wire       tick_64;
	wire       tick_256;
	wire       carrier;
	wire       carrier_fall;

	function is_rf;
		input [7:0] a;
		input [7:0] r;
		begin
			is_rf = rf_write && (a == r);
		end
	endfunction

	wire ctl_wr   = is_rf(rf_addr, `RF_TIMER_CONTROL);
	wire flag_wr  = is_rf(rf_addr, `RF_TIMER_FLAG);
	wire cc_wr    = is_rf(rf_addr, `RF_CARRIER_CONTROL);
	wire clr_req  = ctl_wr && rf_wdata[`TC_CLEAR_BIT];

	// ****************************************************************
	// Clock dividers
	// ****************************************************************
	osc_divider osc_divider_i (
		.clock    (clock),
		.reset_n  (reset_n),
		.tick_2   (tick_2),
		.tick_32  (tick_32),
		.tick_64  (tick_64),
		.tick_256 (tick_256)
	);

	// ****************************************************************
	// Carrier generator
	// ****************************************************************
	wire [1:0] sel      = {timer_clk_sel_hi_ff, timer_clk_sel_lo_ff};
	wire       on_carr  = (sel == `SEL_CARRIER);
	wire       gen_run  = carrier_enable_ff || on_carr;
	wire       gen_tick = (GEN_UNDIVIDED != 0) ? 1'b1 : tick_2;

	carrier_gen #(
		.CNT_W (7)
	) carrier_gen_i (
		.clock       (clock),
		.reset_n     (reset_n),
		.run         (gen_run),
		.gen_tick    (gen_tick),
		.high_period (carrier_high_period_ff[6:0]),
		.low_period  (carrier_low_period_ff[6:0]),
		.carrier_ff  (carrier),
		.fall        (carrier_fall)
	);

	// ****************************************************************
	// Timer count clock select
	// ****************************************************************
	reg count_tick;

	// Carrier fall is the count clock when the carrier is selected
	always @* begin
		case (sel)
		`SEL_DIV32:   count_tick = tick_32;
		`SEL_DIV64:   count_tick = tick_64;
		`SEL_DIV256:  count_tick = tick_256;
		default:      count_tick = carrier_fall;
		endcase
	end

	// ****************************************************************
	// 8-bit timer
	// ****************************************************************
	// Zero limit is never matched, so the flag never rises
	wire match_now = (timer_count_value_ff == timer_match_limit_ff) &&
	                 (timer_match_limit_ff != 8'h00);
	// Wrap guard: a count resting at the limit raises one event only
	wire timer_evt = match_now && !wrap_ff && timer_count_enable_ff && !clr_req;

	localparam [3:0] CTL_RESET = `RST_TIMER_CONTROL;

	reg  [7:0] nxt_count;
	reg        nxt_wrap;
	reg        nxt_flag;

	// Count, wrap guard and match flag next values
	always @* begin
		nxt_count = timer_count_value_ff;
		nxt_wrap  = wrap_ff;
		if (clr_req) begin
			nxt_count = `RST_TIMER_COUNT;
			nxt_wrap  = 1'b0;
		end else if (timer_count_enable_ff && count_tick) begin
			nxt_wrap = 1'b0;
			if (match_now)
				nxt_count = 8'h00;
			else
				nxt_count = timer_count_value_ff + 8'h01;
		end else if (timer_evt) begin
			nxt_wrap = 1'b1;
		end
		// Set wins over flag_clear and a flag register write; the clear strobe blocks the set
		nxt_flag = match_flag_ff;
		if (timer_evt)
			nxt_flag = 1'b1;
		else if (clr_req || flag_clear || (flag_wr && !rf_wdata[`TF_MATCH_BIT]))
			nxt_flag = 1'b0;
	end

	always @(posedge clock) begin
		if (!reset_n) begin
			timer_count_value_ff  <= `RST_TIMER_COUNT;
			wrap_ff               <= 1'b0;
			timer_count_enable_ff <= CTL_RESET[`TC_ENABLE_BIT];
			timer_clk_sel_hi_ff   <= CTL_RESET[`TC_SEL_HI_BIT];
			timer_clk_sel_lo_ff   <= CTL_RESET[`TC_SEL_LO_BIT];
			match_flag_ff         <= 1'b0;
		end else begin
			if (ctl_wr) begin
				timer_count_enable_ff <= rf_wdata[`TC_ENABLE_BIT];
				timer_clk_sel_hi_ff   <= rf_wdata[`TC_SEL_HI_BIT];
				timer_clk_sel_lo_ff   <= rf_wdata[`TC_SEL_LO_BIT];
			end
			timer_count_value_ff <= nxt_count;
			wrap_ff              <= nxt_wrap;
			match_flag_ff        <= nxt_flag;
		end
	end

	assign timer_match_flag = match_flag_ff;

	// ****************************************************************
	// Peripheral registers over the data buffer
	// ****************************************************************
	always @(posedge clock) begin
		if (!reset_n) begin
			timer_match_limit_ff   <= `RST_TIMER_LIMIT;
			carrier_high_period_ff <= `RST_CARRIER_HIGH;
			carrier_low_period_ff  <= `RST_CARRIER_LOW;
			periph_rdata_ff        <= 8'h00;
		end else begin
			// Count register writes fall through the default and are lost
			if (periph_put) begin
				case (periph_addr)
				`PR_TIMER_MATCH_LIMIT:   timer_match_limit_ff   <= data_transfer_buffer;
				`PR_CARRIER_HIGH_PERIOD: carrier_high_period_ff <= data_transfer_buffer;
				`PR_CARRIER_LOW_PERIOD:  carrier_low_period_ff  <= data_transfer_buffer;
				default: ;
				endcase
			end
			// Limit and unmapped reads return zero
			if (periph_get) begin
				case (periph_addr)
				`PR_TIMER_COUNT_VALUE:   periph_rdata_ff <= timer_count_value_ff;
				`PR_CARRIER_HIGH_PERIOD: periph_rdata_ff <= carrier_high_period_ff;
				`PR_CARRIER_LOW_PERIOD:  periph_rdata_ff <= carrier_low_period_ff;
				default:                 periph_rdata_ff <= 8'h00;
				endcase
			end
		end
	end

	// ****************************************************************
	// Output enable, buffer bit and deferred update
	// ****************************************************************
	wire hold_hi = carrier_enable_ff && carrier;

	reg  nxt_enable;
	reg  nxt_pending;
	reg  nxt_pending_val;

	// A timer event while the enabled carrier is high waits for the carrier low phase
	always @* begin
		nxt_enable      = carrier_enable_ff;
		nxt_pending     = pending_ff;
		nxt_pending_val = pending_val_ff;
		if (cc_wr) begin
			nxt_enable  = rf_wdata[`CC_ENABLE_BIT];
			nxt_pending = 1'b0;
		end else if (timer_evt) begin
			if (hold_hi) begin
				nxt_pending     = 1'b1;
				nxt_pending_val = carrier_enable_buffer_ff;
			end else begin
				nxt_enable  = carrier_enable_buffer_ff;
				nxt_pending = 1'b0;
			end
		end else if (pending_ff && !carrier) begin
			nxt_enable  = pending_val_ff;
			nxt_pending = 1'b0;
		end
	end

	always @(posedge clock) begin
		if (!reset_n) begin
			carrier_enable_ff        <= 1'b0;
			carrier_enable_buffer_ff <= 1'b0;
			pending_ff               <= 1'b0;
			pending_val_ff           <= 1'b0;
		end else begin
			if (cc_wr)
				carrier_enable_buffer_ff <= rf_wdata[`CC_BUFFER_BIT];
			carrier_enable_ff <= nxt_enable;
			pending_ff        <= nxt_pending;
			pending_val_ff    <= nxt_pending_val;
		end
	end

	// ****************************************************************
	// Remote output pin
	// ****************************************************************
	// Pin follows the carrier one clock late, from a flip-flop
	reg nxt_pin;

	always @* begin
		if (!carrier_enable_ff)
			nxt_pin = 1'b0;
		else if (carrier_low_period_ff[`LOW_STEADY_BIT])
			nxt_pin = 1'b1;
		else
			nxt_pin = carrier;
	end

	always @(posedge clock) begin
		if (!reset_n)
			remote_output_pin <= 1'b0;
		else
			remote_output_pin <= nxt_pin;
	end

	// ****************************************************************
	// Register file read
	// ****************************************************************
	reg  [3:0] nxt_rf_rdata;

	// Read data follow the address one clock later
	always @* begin
		case (rf_addr)
		`RF_TIMER_CONTROL:   nxt_rf_rdata = {timer_count_enable_ff, 1'b0,
		                                     timer_clk_sel_hi_ff, timer_clk_sel_lo_ff};
		`RF_TIMER_FLAG:      nxt_rf_rdata = {3'h0, match_flag_ff};
		`RF_CARRIER_CONTROL: nxt_rf_rdata = {2'h0, carrier_enable_buffer_ff,
		                                     carrier_enable_ff};
		default:             nxt_rf_rdata = 4'h0;
		endcase
	end

	always @(posedge clock) begin
		if (!reset_n)
			rf_rdata_ff <= 4'h0;
		else
			rf_rdata_ff <= nxt_rf_rdata;
	end
endmodule // ir_timer_carrier_gen

// >>> rtl/ir_timer_map.vh
`ifndef IR_TIMER_MAP_VH
`define IR_TIMER_MAP_VH

// ****************************************************************
// Peripheral register addresses (data buffer access)
// ****************************************************************
`define PR_TIMER_COUNT_VALUE   8'h05
`define PR_TIMER_MATCH_LIMIT   8'h06
`define PR_CARRIER_HIGH_PERIOD 8'h07
`define PR_CARRIER_LOW_PERIOD  8'h08

// ****************************************************************
// Register file addresses and fields
// ****************************************************************
`define RF_TIMER_CONTROL       8'h33
`define RF_TIMER_FLAG          8'h3f
`define RF_CARRIER_CONTROL     8'h34
`define TC_ENABLE_BIT          3
`define TC_CLEAR_BIT           2
`define TC_SEL_HI_BIT          1
`define TC_SEL_LO_BIT          0
`define TF_MATCH_BIT           0
`define CC_ENABLE_BIT          0
`define CC_BUFFER_BIT          1
`define LOW_STEADY_BIT         7

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_TIMER_COUNT        8'h00
`define RST_TIMER_LIMIT        8'hff
`define RST_TIMER_CONTROL      4'h8
`define RST_CARRIER_HIGH       8'h00
`define RST_CARRIER_LOW        8'h00

// ****************************************************************
// Clock source codes and divide ratios
// ****************************************************************
`define SEL_DIV32              2'h0
`define SEL_DIV64              2'h1
`define SEL_DIV256             2'h2
`define SEL_CARRIER            2'h3
`define DIV_WIDTH              8

`endif

// >>> rtl/osc_divider.v
`include "ir_timer_map.vh"

// ****************************************************************
// Free running divider: one-cycle ticks at fx/2, fx/32, fx/64, fx/256
// ****************************************************************
module osc_divider (
	input  wire       clock,    // System oscillator clock
	input  wire       reset_n,  // Synchronous reset, active low
	output wire       tick_2,   // Pulse every 2 clocks
	output wire       tick_32,  // Pulse every 32 clocks
	output wire       tick_64,  // Pulse every 64 clocks
	output wire       tick_256  // Pulse every 256 clocks
);
	reg  [`DIV_WIDTH-1:0] div_ff;

	always @(posedge clock) begin
		if (!reset_n)
			div_ff <= {`DIV_WIDTH{1'b0}};
		else
			div_ff <= div_ff + 8'h01;
	end

	assign tick_2   = div_ff[0];
	assign tick_32  = (div_ff[4:0] == 5'h1f);
	assign tick_64  = (div_ff[5:0] == 6'h3f);
	assign tick_256 = (div_ff == 8'hff);
endmodule // osc_divider
